// file: fsg_frame_signature_unit.sv
/*
  Frame signature unit: indexed control/result registers, vsync-aligned capture,
  MISR compression of displayed pixels, pseudo-random memory data source.
  Assumes pixel, vsync and luma inputs are async pins; register port is synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module fsg_frame_signature_unit (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        idx_wr,
  input  wire logic [7:0]  idx_wdata,
  input  wire logic        dat_wr,
  input  wire logic        dat_rd,
  input  wire logic [7:0]  dat_wdata,
  output logic      [7:0]  dat_rdata,
  input  wire logic        vsync_in,
  input  wire logic        pixel_valid_in,
  input  wire logic [15:0] pixel_in,
  input  wire logic        blt_valid,
  input  wire logic [15:0] blt_data,
  input  wire logic [7:0]  video_port_luma_lines,
  output logic      [63:0] mem_data_force,
  output logic             mem_force_en,
  output logic             capture_busy
);
  import fsg_pkg::*;

  typedef struct packed {
    logic [7:0]  index;
    logic [7:0]  ctrl;
    fsg_state_e  state;
    logic [15:0] result;
    logic [15:0] prbs;
    logic [63:0] mem_q;
    logic [7:0]  rdata;
    logic        vs_s1;
    logic        vs_s2;
    logic        vs_d;
    logic        pv_s1;
    logic        pv_s2;
    logic [15:0] px_s1;
    logic [15:0] px_s2;
    logic [7:0]  ly_s1;
    logic [7:0]  ly_s2;
  } fsg_unit_s;

  fsg_unit_s   st_reg;
  fsg_unit_s   st_next;
  logic        misr_clr;
  logic        misr_step;
  logic [15:0] misr_din;
  logic [15:0] misr_sig;
  logic        vs_rise;
  logic        luma_bit;

  // ==========================================================
  // Helper functions
  // Free-running source for the memory data bus
  function automatic logic [15:0] prbs_step(input logic [15:0] v);
    prbs_step = {v[14:0], v[15] ^ v[14] ^ v[12] ^ v[3]};
  endfunction : prbs_step

  // One place decides whether an index names a register
  function automatic logic idx_is(input logic [7:0] index, input logic [7:0] target);
    idx_is = (index == target);
  endfunction : idx_is

  // Read mux; unmapped indices read as zero
  function automatic logic [7:0] read_mux(
    input logic [7:0]  index,
    input logic [7:0]  ctrl,
    input logic [15:0] result
  );
    read_mux = 8'h00;
    if (idx_is(index, FSG_IDX_CTRL)) begin
      read_mux = ctrl;
    end
    if (idx_is(index, FSG_IDX_RES_LO)) begin
      read_mux = result[7:0];
    end
    if (idx_is(index, FSG_IDX_RES_HI)) begin
      read_mux = result[15:8];
    end
  endfunction : read_mux

  // ==========================================================
  // Input synchronisers feed only their second stage
  assign vs_rise  = st_reg.vs_s2 & ~st_reg.vs_d;
  assign luma_bit = st_reg.ly_s2[st_reg.ctrl[FSG_SEL_LSB +: 3]];

  // ==========================================================
  // Compressor input and step
  // Displayed pixel values, not memory, feed the compressor
  always_comb begin
    misr_din = st_reg.px_s2 ^ {15'h0000, luma_bit};
    if (st_reg.ctrl[FSG_BIT_BLT] && blt_valid) begin
      misr_din = misr_din ^ blt_data;
    end
  end

  // Bit 6 is stored for readback only and steers nothing
  // The closing vsync edge belongs to the next frame and takes no step
  always_comb begin
    misr_step = 1'b0;
    if (st_reg.state == FSG_RUN && !vs_rise) begin
      misr_step = st_reg.pv_s2;
      if (st_reg.ctrl[FSG_BIT_BLT] && blt_valid) begin
        misr_step = 1'b1;
      end
    end
  end

  // ==========================================================
  // Control and capture sequencing
  always_comb begin
    st_next  = st_reg;
    misr_clr = 1'b0;

    // Two flops on each vsync, pixel valid, pixel and luma pin before any logic reads it
    st_next.vs_s1 = vsync_in;
    st_next.vs_s2 = st_reg.vs_s1;
    st_next.vs_d  = st_reg.vs_s2;
    st_next.pv_s1 = pixel_valid_in;
    st_next.pv_s2 = st_reg.pv_s1;
    st_next.px_s1 = pixel_in;
    st_next.px_s2 = st_reg.px_s1;
    st_next.ly_s1 = video_port_luma_lines;
    st_next.ly_s2 = st_reg.ly_s1;
    st_next.prbs  = prbs_step(st_reg.prbs);

    // Capture spans one vsync rise to the next
    case (st_reg.state)
      FSG_IDLE: begin
        st_next.state = FSG_IDLE;
      end
      FSG_ARMED: begin
        if (vs_rise) begin
          misr_clr      = 1'b1;
          st_next.state = FSG_RUN;
        end
      end
      FSG_RUN: begin
        if (vs_rise) begin
          st_next.result           = misr_sig;
          st_next.state            = FSG_IDLE;
          st_next.ctrl[FSG_BIT_GO] = 1'b0;
        end
      end
      default: begin
        st_next.state = FSG_IDLE;
      end
    endcase

    // Index port
    if (idx_wr) begin
      st_next.index = idx_wdata;
    end

    // Data port write; the result registers ignore writes
    if (dat_wr && idx_is(st_reg.index, FSG_IDX_CTRL)) begin
      st_next.ctrl = dat_wdata;
      if (dat_wdata[FSG_BIT_RST]) begin
        st_next.state            = FSG_IDLE;
        st_next.ctrl[FSG_BIT_GO] = 1'b0;
        misr_clr                 = 1'b1;
      end else if (dat_wdata[FSG_BIT_GO]) begin
        // Re-arm restarts cleanly from the next vsync
        st_next.state = FSG_ARMED;
      end else begin
        // A frame ending in this same cycle still drops the busy bit
        st_next.ctrl[FSG_BIT_GO] = st_reg.ctrl[FSG_BIT_GO]
                                   && (st_next.state != FSG_IDLE);
        if (!st_reg.ctrl[FSG_BIT_GO]) begin
          st_next.state = FSG_IDLE;
        end
      end
    end

    // Data and enable move on the same edge
    if (st_next.ctrl[FSG_BIT_PRAND]) begin
      st_next.mem_q = {4{st_reg.prbs}};
    end else begin
      st_next.mem_q = 64'h0000_0000_0000_0000;
    end

    // Read data registered one cycle after the strobe, held until the next
    if (dat_rd) begin
      st_next.rdata = read_mux(st_reg.index, st_reg.ctrl, st_reg.result);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg       <= '0;
      st_reg.ctrl  <= FSG_CTRL_RESET;
      st_reg.state <= FSG_IDLE;
      st_reg.prbs  <= FSG_PRBS_SEED;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Compressor
  fsg_misr u_misr (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .clr     (misr_clr),
    .step    (misr_step),
    .din     (misr_din),
    .sig     (misr_sig)
  );

  // ==========================================================
  // Outputs, all straight from flip-flops
  assign dat_rdata      = st_reg.rdata;
  assign mem_data_force = st_reg.mem_q;
  assign mem_force_en   = st_reg.ctrl[FSG_BIT_PRAND];
  assign capture_busy   = st_reg.ctrl[FSG_BIT_GO];
endmodule : fsg_frame_signature_unit
`default_nettype wire

// file: fsg_pkg.sv
/*
  Constants and types for the frame signature unit.
  Assumes an indexed register port (index write, data read/write) on sys_clk.
*/
// What this block does
// - Compute a 16-bit signature over one frame of displayed pixels.
// - Signature uses final displayed pixel values, not memory contents.
// - Control bit 7 enables block-transfer engine signature capture.
// - Control bit 6 has no effect on signature generation.
// - Control bit 5 forces pseudo-random data onto memory data bus.
// - Control bits 4:2 pick one of eight luma lines as input.
// - Control bit 1 aborts and resets any running signature.
// - Writing bit 0 arms; accumulation starts at next vertical sync.
// - Bit 0 reads 1 while running, self-clears when result ready.
// - Result low byte at next index, high byte at index after.
`default_nettype none
package fsg_pkg;
  // ==========================================================
  // Register indices
  localparam logic [7:0] FSG_IDX_CTRL     = 8'h18;
  localparam logic [7:0] FSG_IDX_RES_LO   = 8'h19;
  localparam logic [7:0] FSG_IDX_RES_HI   = 8'h1a;
  // ==========================================================
  // Control fields
  localparam int         FSG_BIT_BLT      = 7;
  localparam int         FSG_BIT_SPARE    = 6;
  localparam int         FSG_BIT_PRAND    = 5;
  localparam int         FSG_SEL_LSB      = 2;
  localparam int         FSG_BIT_RST      = 1;
  localparam int         FSG_BIT_GO       = 0;
  localparam logic [7:0] FSG_CTRL_RESET   = 8'h00;
  localparam logic [15:0] FSG_MISR_POLY   = 16'h1021;
  localparam logic [15:0] FSG_PRBS_SEED   = 16'hace1;

  // ==========================================================
  // Capture states
  typedef enum logic [1:0] {
    FSG_IDLE  = 2'b00,
    FSG_ARMED = 2'b01,
    FSG_RUN   = 2'b10
  } fsg_state_e;
endpackage : fsg_pkg
`default_nettype wire

// file: fsg_misr.sv
/*
  16-bit multiple-input signature register, one step per enable.
  Assumes clear and step come from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module fsg_misr (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        clr,
  input  wire logic        step,
  input  wire logic [15:0] din,
  output logic      [15:0] sig
);
  import fsg_pkg::*;

  typedef struct packed {
    logic [15:0] sig;
  } fsg_misr_s;

  fsg_misr_s st_reg;
  fsg_misr_s st_next;

  // ==========================================================
  // Compression step
  always_comb begin
    st_next = st_reg;
    if (clr) begin
      st_next.sig = 16'h0000;
    end else if (step) begin
      st_next.sig = ({st_reg.sig[14:0], 1'b0}
                    ^ (st_reg.sig[15] ? FSG_MISR_POLY : 16'h0000)) ^ din;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) st_reg <= '0;
    else st_reg <= st_next;
  end

  assign sig = st_reg.sig;
endmodule : fsg_misr
`default_nettype wire

// file: fsg_checker.sv
/* Port checker for fsg_frame_signature_unit.
   Assumes one sys_clk domain and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module fsg_checker (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        idx_wr,
  input wire logic [7:0]  idx_wdata,
  input wire logic        dat_wr,
  input wire logic        dat_rd,
  input wire logic [7:0]  dat_wdata,
  input wire logic [7:0]  dat_rdata,
  input wire logic        vsync_in,
  input wire logic [63:0] mem_data_force,
  input wire logic        mem_force_en,
  input wire logic        capture_busy
);
  import fsg_pkg::*;

  // ==========================================================
  // Shadow index: same-cycle index write uses the old index
  logic [7:0] ix_reg;
  logic       wctl;
  always_ff @(posedge sys_clk) ix_reg <= sys_rst ? 8'h00 : (idx_wr ? idx_wdata : ix_reg);
  assign wctl = dat_wr && ix_reg == FSG_IDX_CTRL;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_arm; wctl && dat_wdata[1:0] == 2'b01 |=> capture_busy; endproperty
  a_arm: assert property (p_arm) else $error("arm write not busy");
  property p_rst; wctl && dat_wdata[1] |=> !capture_busy; endproperty
  a_rst: assert property (p_rst) else $error("reset left busy");
  property p_noarm; wctl && !dat_wdata[0] && !capture_busy |=> !capture_busy; endproperty
  a_noarm: assert property (p_noarm) else $error("busy without arm");
  property p_done; $fell(capture_busy) && !$past(wctl)
    |-> $past(vsync_in, 2) || $past(vsync_in, 4) || $past(vsync_in, 6); endproperty
  a_done: assert property (p_done) else $error("done without vsync");
  property p_rdst; dat_rd && ix_reg == FSG_IDX_CTRL |=> dat_rdata[0] == $past(capture_busy);
  endproperty
  a_rdst: assert property (p_rdst) else $error("status bit read wrong");
  property p_hold; !dat_rd |=> $stable(dat_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_fen; wctl |=> mem_force_en == $past(dat_wdata[5]); endproperty
  a_fen: assert property (p_fen) else $error("force enable wrong");
  property p_fzero; !mem_force_en |-> mem_data_force == 64'h0; endproperty
  a_fzero: assert property (p_fzero) else $error("force data not zero");
  property p_unmap; dat_rd && ix_reg != FSG_IDX_CTRL && ix_reg != FSG_IDX_RES_LO
    && ix_reg != FSG_IDX_RES_HI |=> dat_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  c_arm: cover property (wctl && dat_wdata[0]);
  c_done: cover property ($fell(capture_busy));
  c_force: cover property (mem_force_en);
endmodule : fsg_checker
bind fsg_frame_signature_unit fsg_checker fsg_checker_inst (.sys_clk, .sys_rst, .idx_wr,
  .idx_wdata, .dat_wr, .dat_rd, .dat_wdata, .dat_rdata, .vsync_in, .mem_data_force,
  .mem_force_en, .capture_busy);
`default_nettype wire

// file: fsg_frame_signature_unit_bench.sv
/* Self-checking bench for the frame signature unit.
   Assumes fsg_pkg, the unit and its checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module fsg_frame_signature_unit_bench;
  import fsg_pkg::*;
  logic        sys_clk = 1'b0, sys_rst = 1'b1, idx_wr = 1'b0, dat_wr = 1'b0, dat_rd = 1'b0;
  logic        vsync_in = 1'b0, pixel_valid_in = 1'b0, mem_force_en, capture_busy;
  logic        blt_valid = 1'b0;
  logic [7:0]  idx_wdata = 8'h00, dat_wdata = 8'h00, dat_rdata, luma = 8'h00, v;
  logic [15:0] pixel_in = 16'h0000, blt_data = 16'h0000, s0, s1, s2;
  logic [63:0] mem_data_force;
  int          err_total = 0, comparisons = 0, k;
  always #12.5 sys_clk = ~sys_clk;
  fsg_frame_signature_unit fsg_frame_signature_unit_inst (.sys_clk, .sys_rst, .idx_wr,
    .idx_wdata, .dat_wr, .dat_rd, .dat_wdata, .dat_rdata, .vsync_in, .pixel_valid_in,
    .pixel_in, .blt_valid, .blt_data, .video_port_luma_lines(luma),
    .mem_data_force, .mem_force_en, .capture_busy);
  // ==========================================================
  // Tasks
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(string n, logic [15:0] e, logic [15:0] g, logic same = 1'b1);
    comparisons++;
    if ((g === e) !== same || $isunknown(g)) begin
      err_total++;
      $display("ERROR %s expected %s%h seen %h", n, same ? "" : "not ", e, g);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge sys_clk) idx_wr = 1'b1;
    idx_wdata = a;
    @(negedge sys_clk) idx_wr = 1'b0;
    dat_wr = 1'b1;
    dat_wdata = d;
    @(negedge sys_clk) dat_wr = 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, output logic [7:0] q);
    @(negedge sys_clk) idx_wr = 1'b1;
    idx_wdata = a;
    @(negedge sys_clk) idx_wr = 1'b0;
    dat_rd = 1'b1;
    @(negedge sys_clk) dat_rd = 1'b0;
    q = dat_rdata;
  endtask : rd
  task automatic vs;
    @(negedge sys_clk) vsync_in = 1'b1;
    repeat (4) @(negedge sys_clk);
    vsync_in = 1'b0;
  endtask : vs
  // One frame of 16 pixels between two vsync rises
  task automatic cap(logic [7:0] c, logic [15:0] p, output logic [15:0] s);
    int i;
    wr(8'h18, c | 8'h02);
    wr(8'h18, c);
    wr(8'h18, c | 8'h01);
    rd(8'h18, v);
    chk("armed ctrl", {8'h00, c | 8'h01}, {8'h00, v});
    chk("busy while armed", 16'h0001, {15'h0000, capture_busy});
    vs();
    for (i = 0; i < 16; i++) begin
      @(negedge sys_clk) pixel_valid_in = 1'b1;
      pixel_in = p + 16'(i);
    end
    @(negedge sys_clk) pixel_valid_in = 1'b0;
    repeat (4) @(negedge sys_clk);
    vs();
    rd(8'h18, v);
    for (i = 0; i < 20 && v[0] !== 1'b0; i++) rd(8'h18, v);
    chk("done bit", 16'h0000, {15'h0000, v[0]});
    rd(8'h19, s[7:0]);
    rd(8'h1a, s[15:8]);
  endtask : cap
  // ==========================================================
  // Tests
  initial begin
    repeat (10) @(negedge sys_clk);
    sys_rst = 1'b0;
    rd(8'h18, v);
    chk("ctrl after reset", 16'h0000, {8'h00, v});
    cap(8'h00, 16'h0100, s0);
    cap(8'h40, 16'h0100, s1);
    chk("repeat signature", s0, s1);
    cap(8'h00, 16'h0101, s2);
    chk("pixel change", s0, s2, 1'b0);
    $display("signature tests done");
    for (k = 0; k < 8; k++) begin
      luma = 8'h01 << k;
      cap(8'(k << 2), 16'h0100, s1);
      chk("luma line", s0, s1, 1'b0);
      cap(8'(((k + 1) % 8) << 2), 16'h0100, s2);
      chk("other line", s0, s2);
    end
    $display("line select tests done");
    blt_valid = 1'b1;
    blt_data  = 16'h00ff;
    cap(8'h00, 16'h0100, s1);
    chk("engine off", s0, s1);
    cap(8'h80, 16'h0100, s2);
    chk("engine on", s0, s2, 1'b0);
    blt_valid = 1'b0;
    $display("engine tests done");
    wr(8'h18, 8'h01);
    wr(8'h18, 8'h02);
    rd(8'h18, v);
    chk("abort", 16'h0002, {8'h00, v});
    chk("busy after abort", 16'h0000, {15'h0000, capture_busy});
    wr(8'h18, 8'h20);
    chk("force enable", 16'h0001, {15'h0000, mem_force_en});
    chk("prbs data", 16'h0000, mem_data_force[15:0], 1'b0);
    wr(8'h18, 8'h00);
    chk("force disable", 16'h0000, {15'h0000, mem_force_en});
    chk("normal data", 16'h0000, mem_data_force[15:0]);
    wr(8'h19, 8'h5a);
    rd(8'h19, v);
    chk("result read-only", {8'h00, s2[7:0]}, {8'h00, v});
    rd(8'h33, v);
    chk("unmapped", 16'h0000, {8'h00, v});
    $display("register tests done");
    report_and_stop();
  end
  // About 20 captures of under 200 cycles each
  initial begin
    #1000000;
    err_total++;
    report_and_stop();
  end
endmodule : fsg_frame_signature_unit_bench
`default_nettype wire
